// ==== evfu_mem_model.sv ====
// Memory model holding the exception vector table and the stack area.
// Assumes one aligned longword access per request, answered after lat cycles.
`timescale 1ns/1ns
`default_nettype none
module evfu_mem_model (
  // Clock.
  input wire logic clk,
  // Access from the unit.
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic mem_ack,
  output logic [31:0] mem_rdata,
  // Answer latency in cycles.
  input wire logic [3:0] lat
);
  logic [31:0] mem [0:255];
  logic [3:0] cnt;
  logic [31:0] last;

  initial begin
    cnt = 4'h0;
    last = 32'h00000000;
    for (int i = 0; i < 256; i++) begin
      mem[i] = 32'hc0de0000 | i;
    end
  end

  assign mem_ack = mem_req && (cnt >= lat);
  // Data lines show no stale value outside an answer.
  assign mem_rdata = mem_ack ? mem[mem_addr[9:2]] : ~last;

  always @(posedge clk) begin
    cnt <= (mem_req && !mem_ack) ? cnt + 4'h1 : 4'h0;
    if (mem_ack && mem_we) begin
      mem[mem_addr[9:2]] <= mem_wdata;
    end
    if (mem_ack) begin
      last <= mem_rdata;
    end
  end
endmodule : evfu_mem_model
`default_nettype wire

// ==== evfu_pkg.sv ====
// Holds the types and address helpers of the exception vector fetch unit.
// Assumes the constants header is on the include path.
`include "evfu_regs.svh"
package evfu_pkg;
  typedef enum logic [3:0] {
    evfu_k_ill_gen, evfu_k_ill_slot, evfu_k_cpu_ae, evfu_k_dma_ae, evfu_k_nmi,
    evfu_k_ubrk, evfu_k_dbg, evfu_k_trap, evfu_k_irq_line, evfu_k_irl_level, evfu_k_periph
  } evfu_kind_t;

  typedef struct packed {
    evfu_kind_t kind;
    logic [7:0] num;
    logic [3:0] level;
    logic use_ext;
    logic [7:0] ext_vec;
  } evfu_req_t;

  typedef struct packed {
    logic [31:0] pc;
    logic [31:0] stack;
    logic [31:0] status;
  } evfu_ctx_t;

  typedef enum logic [2:0] {
    evfu_st_hold, evfu_st_rst_pc, evfu_st_rst_sp, evfu_st_idle,
    evfu_st_push_sr, evfu_st_push_pc, evfu_st_fetch_vec, evfu_st_finish
  } evfu_state_t;

  function automatic logic [31:0] evfu_vec_addr(input logic [31:0] base, input logic [7:0] num);
    evfu_vec_addr = base + {22'h000000, num, 2'b00};
  endfunction : evfu_vec_addr

  function automatic logic [31:0] evfu_set_mask(input logic [31:0] sw, input logic [3:0] m);
    logic [31:0] r;
    r = sw;
    r[`EVFU_MASK_LSB +: 4] = m;
    evfu_set_mask = r;
  endfunction : evfu_set_mask
endpackage : evfu_pkg

// ==== evfu_regs.svh ====
// Holds vector numbers, field positions, reset values and frame sizes for the exception unit.
// Assumes a 32-bit status word and a byte-addressed vector table in memory.
`ifndef EVFU_REGS_SVH
`define EVFU_REGS_SVH
`define EVFU_VEC_POR_PC 8'h00
`define EVFU_VEC_POR_SP 8'h01
`define EVFU_VEC_MAN_PC 8'h02
`define EVFU_VEC_MAN_SP 8'h03
`define EVFU_VEC_ILL_GEN 8'h04
`define EVFU_VEC_ILL_SLOT 8'h06
`define EVFU_VEC_CPU_AE 8'h09
`define EVFU_VEC_DMA_AE 8'h0a
`define EVFU_VEC_NMI 8'h0b
`define EVFU_VEC_UBRK 8'h0c
`define EVFU_VEC_DBG 8'h0d
`define EVFU_VEC_AUTO_BASE 8'h40
`define EVFU_VEC_AUTO_LAST 8'h47
`define EVFU_VBR_RESET 32'h00000000
`define EVFU_STATUS_RESET 32'h00000000
`define EVFU_MASK_RESET 4'hf
`define EVFU_MASK_LSB 4
`define EVFU_WORD_BYTES 32'h00000004
`define EVFU_FRAME_BYTES 32'h00000008
`endif

// ==== evfu_tb.sv ====
// Testbench for the exception entry sequencer.
// Assumes the memory model answers with the latency set by the bench.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk, sys_rst, reset_pin_n, nmi_pin, exc_req, exc_ready, vbr_wr;
  logic mem_req, mem_we, mem_ack, exec_start, reset_active, reset_manual;
  logic dma_addr_err_flag, enet_dma_addr_err_flag;
  logic [31:0] vbr_wdata, mem_addr, mem_wdata, mem_rdata, vector_base_reg;
  logic [1:0] dma_ae_set, dma_ae_clr;
  logic [3:0] lat;
  evfu_pkg::evfu_req_t exc_info;
  evfu_pkg::evfu_ctx_t ctx_in, ctx_out;
  int failures = 0;
  int n_compared = 0;

  evfu_top dut (.clk(clk), .sys_rst(sys_rst), .reset_pin_n(reset_pin_n), .nmi_pin(nmi_pin),
    .exc_req(exc_req), .exc_info(exc_info), .exc_ready(exc_ready), .ctx_in(ctx_in),
    .vbr_wr(vbr_wr), .vbr_wdata(vbr_wdata), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .exec_start(exec_start), .ctx_out(ctx_out), .vector_base_reg(vector_base_reg),
    .reset_active(reset_active), .reset_manual(reset_manual), .dma_ae_set(dma_ae_set),
    .dma_ae_clr(dma_ae_clr), .dma_addr_err_flag(dma_addr_err_flag),
    .enet_dma_addr_err_flag(enet_dma_addr_err_flag));
  evfu_mem_model dut_mem (.clk(clk), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .lat(lat));

  always #25 clk = ~clk;

  task automatic final_report;
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Waits for exec_start or exc_ready at a falling edge, within a bound.
  task automatic wait_on(input bit start);
    int i;
    for (i = 0; i < 400; i++) begin
      @(negedge clk);
      if ((start ? exec_start : exc_ready) === 1'b1) break;
    end
    if (i == 400) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, 1'h0, 1'h1);
      final_report();
    end
  endtask : wait_on

  task automatic set_vbr;
    wait_on(1'b0);
    vbr_wr = 1'b1;
    vbr_wdata = 32'h00000040;
    @(negedge clk);
    vbr_wr = 1'b0;
    check(vector_base_reg, 32'h00000040);
  endtask : set_vbr

  task automatic reset_entry(input logic manual);
    wait_on(1'b1);
    check(ctx_out.pc, 32'hc0de0000 | {30'h0, manual, 1'b0});
    check(ctx_out.stack, 32'hc0de0001 | {30'h0, manual, 1'b0});
    check(ctx_out.status, 32'h000000f0);
    check(vector_base_reg, 32'h00000000);
    check({31'h0, reset_manual}, {31'h0, manual});
    $display("test reset entry manual=%0d done", manual);
  endtask : reset_entry

  task automatic run_exc(input evfu_pkg::evfu_kind_t k, input logic [7:0] n,
      input logic [3:0] lv, input logic ue, input logic [7:0] ev, input logic [7:0] vec,
      input logic irq, input logic [3:0] lt);
    logic [31:0] st;
    wait_on(1'b0);
    lat = lt;
    ctx_in = '{pc: 32'h00001234 + 32'(n), stack: 32'h000003f0, status: 32'h00000a35};
    exc_info = '{kind: k, num: n, level: lv, use_ext: ue, ext_vec: ev};
    exc_req = 1'b1;
    @(negedge clk);
    exc_req = 1'b0;
    wait_on(1'b1);
    st = irq ? {24'h00000a, lv, 4'h5} : 32'h00000a35;
    check(ctx_out.pc, 32'hc0de0000 | (32'h00000010 + 32'(vec)));
    check(ctx_out.stack, 32'h000003e8);
    check(ctx_out.status, st);
    check(dut_mem.mem[251], 32'h00000a35);
    check(dut_mem.mem[250], 32'h00001234 + 32'(n));
    $display("test exception vector %0d done", vec);
  endtask : run_exc

  // Every answered access must be longword aligned.
  always @(negedge clk) begin
    if (mem_ack === 1'b1) check({30'h0, mem_addr[1:0]}, 32'h00000000);
  end

  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    reset_pin_n = 1'b1;
    nmi_pin = 1'b1;
    exc_req = 1'b0;
    exc_info = '0;
    ctx_in = '0;
    vbr_wr = 1'b0;
    vbr_wdata = 32'h00000000;
    dma_ae_set = 2'h0;
    dma_ae_clr = 2'h0;
    lat = 4'h2;
    repeat (8) @(negedge clk);
    sys_rst = 1'b0;
    reset_entry(1'b0);
    set_vbr();
    nmi_pin = 1'b0;
    reset_pin_n = 1'b0;
    repeat (25) @(negedge clk);
    check({31'h0, reset_active}, 32'h00000001);
    reset_pin_n = 1'b1;
    reset_entry(1'b1);
    nmi_pin = 1'b1;
    set_vbr();
    run_exc(evfu_pkg::evfu_k_ill_gen, 8'h00, 4'hc, 1'b0, 8'h00, 8'h04, 1'b0, 4'h0);
    run_exc(evfu_pkg::evfu_k_ill_slot, 8'h00, 4'hc, 1'b0, 8'h00, 8'h06, 1'b0, 4'h3);
    run_exc(evfu_pkg::evfu_k_cpu_ae, 8'h00, 4'hc, 1'b0, 8'h00, 8'h09, 1'b0, 4'h1);
    run_exc(evfu_pkg::evfu_k_dma_ae, 8'h00, 4'hc, 1'b0, 8'h00, 8'h0a, 1'b0, 4'h0);
    run_exc(evfu_pkg::evfu_k_trap, 8'h21, 4'hc, 1'b0, 8'h00, 8'h21, 1'b0, 4'h2);
    run_exc(evfu_pkg::evfu_k_nmi, 8'h00, 4'hf, 1'b0, 8'h00, 8'h0b, 1'b1, 4'h0);
    run_exc(evfu_pkg::evfu_k_ubrk, 8'h00, 4'h7, 1'b0, 8'h00, 8'h0c, 1'b1, 4'h1);
    run_exc(evfu_pkg::evfu_k_dbg, 8'h00, 4'h2, 1'b0, 8'h00, 8'h0d, 1'b1, 4'h0);
    for (int i = 0; i < 4; i++) begin
      run_exc(evfu_pkg::evfu_k_irq_line, 8'(i), 4'h9, 1'b0, 8'h00, 8'(64 + i), 1'b1, 4'h0);
    end
    run_exc(evfu_pkg::evfu_k_irl_level, 8'h0e, 4'h1, 1'b0, 8'h00, 8'h40, 1'b1, 4'h0);
    run_exc(evfu_pkg::evfu_k_irl_level, 8'h00, 4'hf, 1'b0, 8'h00, 8'h47, 1'b1, 4'h2);
    run_exc(evfu_pkg::evfu_k_irl_level, 8'h05, 4'ha, 1'b0, 8'h00, 8'h45, 1'b1, 4'h0);
    run_exc(evfu_pkg::evfu_k_irq_line, 8'h01, 4'h6, 1'b1, 8'h55, 8'h55, 1'b1, 4'h1);
    run_exc(evfu_pkg::evfu_k_irl_level, 8'h09, 4'h6, 1'b1, 8'h60, 8'h60, 1'b1, 4'h0);
    run_exc(evfu_pkg::evfu_k_periph, 8'h7f, 4'h4, 1'b0, 8'h00, 8'h7f, 1'b1, 4'h0);
    for (int i = 0; i < 5; i++) begin
      dma_ae_set = 2'(10'h049 >> (2 * i));
      dma_ae_clr = 2'(10'h350 >> (2 * i));
      @(negedge clk);
      check({30'h0, enet_dma_addr_err_flag, dma_addr_err_flag}, 32'(10'h0ed >> (2 * i)) & 32'h3);
    end
    dma_ae_set = 2'h0;
    dma_ae_clr = 2'h0;
    $display("test dma error flags done");
    final_report();
  end
endmodule : testbench
`default_nettype wire

// ==== evfu_top.sv ====
// Holds the exception entry sequencer: reset entry, context push and vector fetch.
// Assumes a memory that answers one aligned longword access per request with mem_ack.
// What this block does
// - Power-on reset reads PC at 0, SP at 4.
// - Manual reset reads PC at 8, SP at 12.
// - Reset clears vector base, sets mask ones.
// - After reset, execution starts at fetched PC.
// - Other exceptions push status and PC on stack.
// - Interrupt entry copies level into mask field.
// - Error and instruction entries keep mask unchanged.
// - Then fetch handler address and start there.
// - Reset table address is vector times four.
// - Others use vector base plus vector times four.
// - Illegal opcode vector 4, slot illegal 6.
// - CPU address error 9, both DMA 10.
// - Direct lines zero to three vector 64-67.
// - Encoded levels pair onto vectors 64 to 71.
// - Encoded pins decode inverted, 1110 is level one.
// - External interrupts may supply their own vector.
// - Peripheral vectors come from the request number, low seven bits.
// - Reset pin rise picks type from NMI.
`timescale 1ns/1ns
`default_nettype none
`include "evfu_regs.svh"
module evfu_top (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Device pins.
  input wire logic reset_pin_n,
  input wire logic nmi_pin,
  // Exception request from the pipeline.
  input wire logic exc_req,
  input wire evfu_pkg::evfu_req_t exc_info,
  output logic exc_ready,
  // Current CPU context and vector base write.
  input wire evfu_pkg::evfu_ctx_t ctx_in,
  input wire logic vbr_wr,
  input wire logic [31:0] vbr_wdata,
  // Memory port.
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  // New context.
  output logic exec_start,
  output evfu_pkg::evfu_ctx_t ctx_out,
  output logic [31:0] vector_base_reg,
  output logic reset_active,
  output logic reset_manual,
  // DMA address error events, clears and sticky flags.
  input wire logic [1:0] dma_ae_set,
  input wire logic [1:0] dma_ae_clr,
  output logic dma_addr_err_flag,
  output logic enet_dma_addr_err_flag
);
  evfu_pkg::evfu_state_t state;
  logic [1:0] pin_s1;
  logic [1:0] pin_s2;
  logic [1:0] pin_s3;
  logic [1:0] pin_stable;
  logic res_prev;
  logic res_rise;
  logic res_low;
  logic from_reset;
  logic irq_lat;
  logic [3:0] lvl_lat;
  logic [7:0] vec_lat;
  logic [1:0] ae_flag;
  logic [7:0] calc_vec;
  logic [3:0] calc_lvl;
  logic calc_irq;
  logic [31:0] seen_pc;
  logic [31:0] saved_status;

  // Pins pass three flops; a level counts once the last two agree.
  for (genvar i = 0; i < 2; i++) begin : g_sync
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        pin_s1[i] <= 1'b0;
        pin_s2[i] <= 1'b0;
        pin_s3[i] <= 1'b0;
        pin_stable[i] <= 1'b0;
      end else begin
        pin_s1[i] <= (i == 0) ? reset_pin_n : nmi_pin;
        pin_s2[i] <= pin_s1[i];
        pin_s3[i] <= pin_s2[i];
        if (pin_s2[i] == pin_s3[i]) begin
          pin_stable[i] <= pin_s3[i];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      res_prev <= 1'b0;
    end else begin
      res_prev <= pin_stable[0];
    end
  end

  assign res_rise = pin_stable[0] && !res_prev;
  assign res_low = !pin_stable[0];

  evfu_vec_calc u_calc (
    .req(exc_info),
    .vec_num(calc_vec),
    .level(calc_lvl),
    .is_irq(calc_irq)
  );

  assign exc_ready = (state == evfu_pkg::evfu_st_idle) && !res_low;
  assign mem_req = (state == evfu_pkg::evfu_st_rst_pc) || (state == evfu_pkg::evfu_st_rst_sp) ||
                   (state == evfu_pkg::evfu_st_push_sr) || (state == evfu_pkg::evfu_st_push_pc) ||
                   (state == evfu_pkg::evfu_st_fetch_vec);
  assign exec_start = (state == evfu_pkg::evfu_st_finish);
  assign reset_active = (state == evfu_pkg::evfu_st_hold);

  // Sequencer; a bus cycle in flight ends before the reset pin takes over.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= evfu_pkg::evfu_st_hold;
      mem_we <= 1'b0;
      mem_addr <= 32'h00000000;
      mem_wdata <= 32'h00000000;
      ctx_out <= '0;
      reset_manual <= 1'b0;
      from_reset <= 1'b0;
      irq_lat <= 1'b0;
      lvl_lat <= 4'h0;
      vec_lat <= 8'h00;
    end else if (res_low && (!mem_req || mem_ack)) begin
      state <= evfu_pkg::evfu_st_hold;
      mem_we <= 1'b0;
    end else begin
      case (state)
        evfu_pkg::evfu_st_hold: begin
          if (res_rise) begin
            reset_manual <= !pin_stable[1];
            from_reset <= 1'b1;
            state <= evfu_pkg::evfu_st_rst_pc;
            mem_we <= 1'b0;
            mem_addr <= evfu_pkg::evfu_vec_addr(32'h00000000,
                          pin_stable[1] ? `EVFU_VEC_POR_PC : `EVFU_VEC_MAN_PC);
          end
        end
        evfu_pkg::evfu_st_rst_pc: begin
          if (mem_ack) begin
            ctx_out.pc <= mem_rdata;
            state <= evfu_pkg::evfu_st_rst_sp;
            mem_addr <= evfu_pkg::evfu_vec_addr(32'h00000000,
                          reset_manual ? `EVFU_VEC_MAN_SP : `EVFU_VEC_POR_SP);
          end
        end
        evfu_pkg::evfu_st_rst_sp: begin
          if (mem_ack) begin
            ctx_out.stack <= mem_rdata;
            ctx_out.status <= evfu_pkg::evfu_set_mask(`EVFU_STATUS_RESET, `EVFU_MASK_RESET);
            state <= evfu_pkg::evfu_st_finish;
          end
        end
        evfu_pkg::evfu_st_idle: begin
          if (exc_req) begin
            ctx_out <= ctx_in;
            from_reset <= 1'b0;
            irq_lat <= calc_irq;
            lvl_lat <= calc_lvl;
            vec_lat <= calc_vec;
            state <= evfu_pkg::evfu_st_push_sr;
            mem_we <= 1'b1;
            mem_addr <= ctx_in.stack - `EVFU_WORD_BYTES;
            mem_wdata <= ctx_in.status;
          end
        end
        evfu_pkg::evfu_st_push_sr: begin
          if (mem_ack) begin
            state <= evfu_pkg::evfu_st_push_pc;
            mem_addr <= ctx_out.stack - `EVFU_FRAME_BYTES;
            mem_wdata <= ctx_out.pc;
          end
        end
        evfu_pkg::evfu_st_push_pc: begin
          if (mem_ack) begin
            ctx_out.stack <= ctx_out.stack - `EVFU_FRAME_BYTES;
            state <= evfu_pkg::evfu_st_fetch_vec;
            mem_we <= 1'b0;
            mem_addr <= evfu_pkg::evfu_vec_addr(vector_base_reg, vec_lat);
          end
        end
        evfu_pkg::evfu_st_fetch_vec: begin
          if (mem_ack) begin
            ctx_out.pc <= mem_rdata;
            if (irq_lat) begin
              ctx_out.status <= evfu_pkg::evfu_set_mask(ctx_out.status, lvl_lat);
            end
            state <= evfu_pkg::evfu_st_finish;
          end
        end
        evfu_pkg::evfu_st_finish: begin
          state <= evfu_pkg::evfu_st_idle;
        end
        default: state <= evfu_pkg::evfu_st_hold;
      endcase
    end
  end

  // Vector base register.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      vector_base_reg <= `EVFU_VBR_RESET;
    end else if (state == evfu_pkg::evfu_st_hold && res_rise) begin
      vector_base_reg <= `EVFU_VBR_RESET;
    end else if (vbr_wr && state == evfu_pkg::evfu_st_idle) begin
      vector_base_reg <= vbr_wdata;
    end
  end

  // Per-engine DMA address error flags; a set beats a clear.
  for (genvar j = 0; j < 2; j++) begin : g_aeflag
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        ae_flag[j] <= 1'b0;
      end else begin
        ae_flag[j] <= dma_ae_set[j] || (ae_flag[j] && !dma_ae_clr[j]);
      end
    end
  end

  assign dma_addr_err_flag = ae_flag[0];
  assign enet_dma_addr_err_flag = ae_flag[1];

  // Observation copies used by the checks below.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      seen_pc <= 32'h00000000;
      saved_status <= 32'h00000000;
    end else begin
      if (state == evfu_pkg::evfu_st_rst_pc && mem_ack) begin
        seen_pc <= mem_rdata;
      end
      if (exc_ready && exc_req) begin
        saved_status <= ctx_in.status;
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_rst_pc_req;
    state == evfu_pkg::evfu_st_rst_pc && mem_req;
  endsequence

  sequence s_exc_done;
    exec_start && !from_reset;
  endsequence

  a_por_pc_addr: assert property (
    (s_rst_pc_req and !reset_manual) |-> mem_addr == 32'h00000000)
    else $error("power-on PC address wrong");
  a_por_sp_addr: assert property (
    state == evfu_pkg::evfu_st_rst_sp && !reset_manual |-> mem_addr == 32'h00000004)
    else $error("power-on SP address wrong");
  a_man_pc_addr: assert property (
    (s_rst_pc_req and reset_manual) |-> mem_addr == 32'h00000008)
    else $error("manual PC address wrong");
  a_man_sp_addr: assert property (
    state == evfu_pkg::evfu_st_rst_sp && reset_manual |-> mem_addr == 32'h0000000c)
    else $error("manual SP address wrong");
  a_reset_init: assert property (
    exec_start && from_reset |-> vector_base_reg == 32'h00000000 && ctx_out.status[7:4] == 4'hf)
    else $error("reset init values wrong");
  a_vbr_clear: assert property (
    state == evfu_pkg::evfu_st_hold && res_rise |=> vector_base_reg == 32'h00000000)
    else $error("vector base not cleared");
  a_reset_pc: assert property (
    exec_start && from_reset |-> ctx_out.pc == seen_pc)
    else $error("reset PC not from table");
  a_push_status: assert property (
    state == evfu_pkg::evfu_st_push_sr |-> mem_we && mem_wdata == ctx_out.status &&
    mem_addr == ctx_out.stack - 32'h00000004)
    else $error("status push wrong");
  a_push_frame: assert property (
    state == evfu_pkg::evfu_st_push_sr && mem_ack |=> mem_we &&
    mem_addr == $past(mem_addr) - 32'h00000004 && state == evfu_pkg::evfu_st_push_pc)
    else $error("stack frame order wrong");
  a_irq_mask: assert property (
    (s_exc_done and irq_lat) |-> ctx_out.status[7:4] == lvl_lat)
    else $error("interrupt mask not loaded");
  a_keep_mask: assert property (
    (s_exc_done and !irq_lat) |-> ctx_out.status[7:4] == saved_status[7:4])
    else $error("mask changed on non-interrupt");
  a_vec_fetch: assert property (
    state == evfu_pkg::evfu_st_fetch_vec && mem_ack |=> exec_start ##1 exc_ready || res_low)
    else $error("handler start missing");
  a_reset_base: assert property (
    (s_rst_pc_req or state == evfu_pkg::evfu_st_rst_sp) |-> mem_addr[31:4] == 28'h0000000)
    else $error("reset address has a base");
  a_vec_addr: assert property (
    state == evfu_pkg::evfu_st_fetch_vec |-> !mem_we &&
    mem_addr == vector_base_reg + {22'h000000, vec_lat, 2'b00})
    else $error("vector address wrong");
  a_slot_vec: assert property (
    exc_req && exc_info.kind == evfu_pkg::evfu_k_ill_slot |-> calc_vec == 8'h06)
    else $error("slot illegal vector wrong");
  a_flag_set: assert property (
    dma_ae_set[0] |=> dma_addr_err_flag)
    else $error("DMA error flag not set");
  a_eflag_set: assert property (
    dma_ae_set[1] |=> enet_dma_addr_err_flag)
    else $error("ethernet DMA error flag not set");
  a_line_vec: assert property (
    exc_req && exc_info.kind == evfu_pkg::evfu_k_irq_line && !exc_info.use_ext
    |-> calc_vec[7:2] == 6'h10 && calc_vec[1:0] == exc_info.num[1:0])
    else $error("direct line vector wrong");
  a_irl_range: assert property (
    exc_req && exc_info.kind == evfu_pkg::evfu_k_irl_level && !exc_info.use_ext
    |-> calc_vec >= 8'h40 && calc_vec <= 8'h47)
    else $error("encoded level vector wrong");
  a_irl_decode: assert property (
    exc_req && exc_info.kind == evfu_pkg::evfu_k_irl_level |-> calc_lvl == ~exc_info.num[3:0])
    else $error("encoded level decode wrong");
  a_ext_vec: assert property (
    exc_req && exc_info.use_ext && exc_info.kind == evfu_pkg::evfu_k_irq_line
    |-> calc_vec == exc_info.ext_vec)
    else $error("external vector ignored");
  a_periph_vec: assert property (
    exc_req && exc_info.kind == evfu_pkg::evfu_k_periph
    |-> calc_vec == {1'b0, exc_info.num[6:0]})
    else $error("peripheral vector wrong");
  a_type_pick: assert property (
    state == evfu_pkg::evfu_st_hold && res_rise |=> reset_manual == !$past(pin_stable[1]))
    else $error("reset type wrong");
  a_word_align: assert property (
    mem_req |-> mem_addr[1:0] == 2'b00)
    else $error("unaligned table access");
endmodule : evfu_top
`default_nettype wire

// ==== evfu_top_dummy_guard.sv ====
// Holds no logic; it only sets the implicit net rule back for files read after it.
// Assumes nothing of its surroundings and may be read in any order.
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// ==== evfu_vec_calc.sv ====
// Holds the vector number decoder for non-reset exceptions.
// Assumes a request that is stable while it is being accepted.
`timescale 1ns/1ns
`default_nettype none
`include "evfu_regs.svh"
module evfu_vec_calc (
  // Request.
  input wire evfu_pkg::evfu_req_t req,
  // Result.
  output logic [7:0] vec_num,
  output logic [3:0] level,
  output logic is_irq
);
  logic [3:0] irl_lvl;

  always_comb begin
    irl_lvl = ~req.num[3:0];
    level = req.level;
    is_irq = 1'b1;
    vec_num = `EVFU_VEC_ILL_GEN;
    case (req.kind)
      evfu_pkg::evfu_k_ill_gen: begin
        vec_num = `EVFU_VEC_ILL_GEN;
        is_irq = 1'b0;
      end
      evfu_pkg::evfu_k_ill_slot: begin
        vec_num = `EVFU_VEC_ILL_SLOT;
        is_irq = 1'b0;
      end
      evfu_pkg::evfu_k_cpu_ae: begin
        vec_num = `EVFU_VEC_CPU_AE;
        is_irq = 1'b0;
      end
      evfu_pkg::evfu_k_dma_ae: begin
        vec_num = `EVFU_VEC_DMA_AE;
        is_irq = 1'b0;
      end
      evfu_pkg::evfu_k_trap: begin
        vec_num = req.num;
        is_irq = 1'b0;
      end
      evfu_pkg::evfu_k_nmi: vec_num = `EVFU_VEC_NMI;
      evfu_pkg::evfu_k_ubrk: vec_num = `EVFU_VEC_UBRK;
      evfu_pkg::evfu_k_dbg: vec_num = `EVFU_VEC_DBG;
      evfu_pkg::evfu_k_irq_line: vec_num = `EVFU_VEC_AUTO_BASE + {6'h00, req.num[1:0]};
      evfu_pkg::evfu_k_irl_level: begin
        vec_num = `EVFU_VEC_AUTO_BASE + {5'h00, irl_lvl[3:1]};
        level = irl_lvl;
      end
      evfu_pkg::evfu_k_periph: vec_num = {1'b0, req.num[6:0]};
      default: vec_num = `EVFU_VEC_ILL_GEN;
    endcase
    if (req.use_ext && (req.kind == evfu_pkg::evfu_k_irq_line ||
                        req.kind == evfu_pkg::evfu_k_irl_level)) begin
      vec_num = req.ext_vec;
    end
  end
endmodule : evfu_vec_calc
`default_nettype wire
